// >>> rtl/ssoc_core.sv
// How it works
// - Self-test 8 s or 500 ms, outputs off
// - Outputs on within 400 ms of actuator
// - Outputs off within 260 ms of removal
// - Channels agree within 10 ms
// - Internal fault detected within 300 ms
// - Clear input held 3 s leaves fault
// - Door-closed output follows actuator presence
// - Fault output active in fault state
// - Own periodic test pulses on both outputs
// - Flag actuator in limit range
// - Green steady normally, off in fault, flashing otherwise
// - Red lamp lit on any fault
module ssoc_core #(
    parameter int CYC_PER_MS = ssoc_pkg::CYC_PER_MS,
    parameter bit SINGLE_FACE = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic actInRange,
    input wire logic actInLimit,
    input wire logic faultClear,
    input wire logic readbackA,
    input wire logic readbackB,
    input wire logic internalFault,
    output logic safety_output_a,
    output logic safety_output_b,
    output logic door_closed_output_alt,
    output logic fault_indicator_output,
    output logic statusLampGreen,
    output logic diagLampRed,
    output logic limitRange
);
    localparam int MW = ssoc_pkg::MS_W;
    localparam int TW = ssoc_pkg::TP_W;
    localparam logic [MW-1:0] SELFTEST_LIM = SINGLE_FACE ?
        MW'(ssoc_pkg::SELFTEST_SHORT_MS) : MW'(ssoc_pkg::SELFTEST_MS);
    localparam logic [MW-1:0] ON_QUAL_LIM = MW'(ssoc_pkg::ON_QUAL_MS);
    localparam logic [MW-1:0] CLR_LIM = MW'(ssoc_pkg::CLR_HOLD_MS);
    localparam logic [MW-1:0] TON_LIM = MW'(ssoc_pkg::TON_MAX_MS);
    localparam logic [MW-1:0] SKEW_LIM = MW'(ssoc_pkg::SKEW_MAX_MS);
    localparam logic [MW-1:0] FDET_LIM = MW'(ssoc_pkg::FLT_DET_MAX_MS);
    localparam logic [TW-1:0] TP_LAST = TW'(ssoc_pkg::TP_PERIOD_MS - 1);
    localparam logic [TW-1:0] TP_WID = TW'(ssoc_pkg::TP_WIDTH_MS);
    localparam logic [TW-1:0] TP_B0 = TW'(ssoc_pkg::TP_B_START_MS);
    localparam logic [TW-1:0] TP_B1 =
        TW'(ssoc_pkg::TP_B_START_MS + ssoc_pkg::TP_WIDTH_MS);
    localparam logic [3:0] MISM_LIM = 4'(ssoc_pkg::MISM_FILT_MS);

    ssoc_time_if tb ();

    ssoc_tick #(
        .CYC_PER_MS(CYC_PER_MS),
        .FLASH_HALF_MS(ssoc_pkg::FLASH_HALF_MS)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .tb(tb)
    );

    // Two-stage synchronisers for all pin inputs
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    wire [5:0] pinsIn = {internalFault, readbackB, readbackA,
                         faultClear, actInLimit, actInRange};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pinsIn;
            sync_r <= meta_r;
        end
    end

    wire presS = sync_r[0];
    wire limS = sync_r[1];
    wire clearS = sync_r[2];
    wire rbA = sync_r[3];
    wire rbB = sync_r[4];
    wire intFaultS = sync_r[5];
    wire msTick = tb.msTick;

    ssoc_pkg::ssoc_state_t state_r;
    ssoc_pkg::ssoc_state_t state_nxt;
    logic [MW-1:0] msCnt_r;
    logic [MW-1:0] msCnt_nxt;
    logic [MW-1:0] clrCnt_r;
    logic [TW-1:0] tpCnt_r;
    logic [3:0] mismCnt_r;

    wire isSelftest = (state_r == ssoc_pkg::ST_SELFTEST);
    wire isOff = (state_r == ssoc_pkg::ST_OFF);
    wire isOn = (state_r == ssoc_pkg::ST_ON);
    wire isFault = (state_r == ssoc_pkg::ST_FAULT);

    // Staggered test pulses, A first then B, only while outputs are on
    wire pulseA = isOn && (tpCnt_r < TP_WID);
    wire pulseB = isOn && (tpCnt_r >= TP_B0) && (tpCnt_r < TP_B1);
    wire driveA = isOn && !pulseA;
    wire driveB = isOn && !pulseB;

    // Readback disagrees with what is driven: short or stuck output
    wire mism = (rbA != safety_output_a) || (rbB != safety_output_b);
    wire ioFault = (mismCnt_r == MISM_LIM);
    wire faultNow = intFaultS || ioFault;
    wire clearDone = isFault && (clrCnt_r == CLR_LIM);

    always_comb begin
        state_nxt = state_r;
        msCnt_nxt = msCnt_r;
        unique case (state_r)
            ssoc_pkg::ST_SELFTEST: begin
                if (faultNow) begin
                    state_nxt = ssoc_pkg::ST_FAULT;
                end else if (msCnt_r == SELFTEST_LIM) begin
                    state_nxt = ssoc_pkg::ST_OFF;
                    msCnt_nxt = '0;
                end else if (msTick) begin
                    msCnt_nxt = msCnt_r + 1'b1;
                end
            end
            ssoc_pkg::ST_OFF: begin
                if (faultNow) begin
                    state_nxt = ssoc_pkg::ST_FAULT;
                end else if (!presS) begin
                    msCnt_nxt = '0;
                end else if (msCnt_r == ON_QUAL_LIM) begin
                    state_nxt = ssoc_pkg::ST_ON;
                    msCnt_nxt = '0;
                end else if (msTick) begin
                    msCnt_nxt = msCnt_r + 1'b1;
                end
            end
            ssoc_pkg::ST_ON: begin
                if (faultNow) begin
                    state_nxt = ssoc_pkg::ST_FAULT;
                end else if (!presS) begin
                    state_nxt = ssoc_pkg::ST_OFF;
                end
            end
            ssoc_pkg::ST_FAULT: begin
                msCnt_nxt = '0;
                if (clearDone) begin
                    state_nxt = ssoc_pkg::ST_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ssoc_pkg::ST_SELFTEST;
            msCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            msCnt_r <= msCnt_nxt;
        end
    end

    // Clear input must stay high for the full hold time
    always_ff @(posedge clk) begin
        if (sys_rst || !isFault || !clearS) begin
            clrCnt_r <= '0;
        end else if (msTick && !clearDone) begin
            clrCnt_r <= clrCnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !isOn) begin
            tpCnt_r <= '0;
        end else if (msTick) begin
            tpCnt_r <= (tpCnt_r == TP_LAST) ? '0 : tpCnt_r + 1'b1;
        end
    end

    // Filtered over a few ms so pulse edges do not trip it
    always_ff @(posedge clk) begin
        if (sys_rst || isFault || !mism) begin
            mismCnt_r <= '0;
        end else if (msTick && !ioFault) begin
            mismCnt_r <= mismCnt_r + 1'b1;
        end
    end

    wire greenNxt = isFault ? 1'b0 :
                    (isOn && !limS) ? 1'b1 : tb.flash;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            safety_output_a <= ssoc_pkg::SAFE_OUT_RST;
            safety_output_b <= ssoc_pkg::SAFE_OUT_RST;
            door_closed_output_alt <= 1'b0;
            fault_indicator_output <= 1'b0;
            statusLampGreen <= 1'b0;
            diagLampRed <= 1'b0;
            limitRange <= 1'b0;
        end else begin
            safety_output_a <= driveA;
            safety_output_b <= driveB;
            door_closed_output_alt <= presS;
            fault_indicator_output <= isFault;
            statusLampGreen <= greenNxt;
            diagLampRed <= isFault;
            limitRange <= presS && limS;
        end
    end

    // Helper counters for the timing checks below
    logic [MW-1:0] onWait_r;
    logic [MW-1:0] skew_r;
    logic [MW-1:0] fltWait_r;

    always_ff @(posedge clk) begin
        if (sys_rst || !(presS && isOff)) begin
            onWait_r <= '0;
        end else if (msTick) begin
            onWait_r <= onWait_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || (safety_output_a == safety_output_b)) begin
            skew_r <= '0;
        end else if (msTick) begin
            skew_r <= skew_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !mism || isFault) begin
            fltWait_r <= '0;
        end else if (msTick) begin
            fltWait_r <= fltWait_r + 1'b1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_selftest_off;
        isSelftest |=> !safety_output_a && !safety_output_b;
    endproperty
    a_selftest_off: assert property (p_selftest_off)
        else $error("Safety output on during self-test");

    property p_selftest_len;
        (isSelftest && state_nxt == ssoc_pkg::ST_OFF) |->
            msCnt_r == SELFTEST_LIM;
    endproperty
    a_selftest_len: assert property (p_selftest_len)
        else $error("Self-test ended at the wrong time");

    property p_on_time;
        onWait_r <= TON_LIM;
    endproperty
    a_on_time: assert property (p_on_time)
        else $error("Outputs not switched on in time");

    property p_off_time;
        (isOn && !presS) |=> !isOn ##1 (!safety_output_a && !safety_output_b);
    endproperty
    a_off_time: assert property (p_off_time)
        else $error("Outputs not switched off after removal");

    property p_skew;
        skew_r <= SKEW_LIM;
    endproperty
    a_skew: assert property (p_skew)
        else $error("Channels disagree too long");

    property p_int_fault;
        (intFaultS && !isFault) |=> isFault ##1 fault_indicator_output;
    endproperty
    a_int_fault: assert property (p_int_fault)
        else $error("Internal fault not taken");

    property p_io_fault_time;
        fltWait_r <= FDET_LIM;
    endproperty
    a_io_fault_time: assert property (p_io_fault_time)
        else $error("Output fault not detected in time");

    property p_clear_hold;
        (isFault && state_nxt != ssoc_pkg::ST_FAULT) |->
            clrCnt_r == CLR_LIM && $past(clearS);
    endproperty
    a_clear_hold: assert property (p_clear_hold)
        else $error("Fault left without a full clear hold");

    property p_door;
        presS [*2] |-> door_closed_output_alt;
    endproperty
    a_door: assert property (p_door)
        else $error("Door-closed output not following actuator");

    property p_fault_out;
        isFault |=> fault_indicator_output && diagLampRed &&
            !safety_output_a && !safety_output_b;
    endproperty
    a_fault_out: assert property (p_fault_out)
        else $error("Fault state not shown or outputs not off");

    property p_pulse;
        (isOn && pulseA) |=> !safety_output_a && safety_output_b;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("Test pulse on channel A missing");

    property p_limit;
        (presS && limS) ##1 (presS && limS) |-> limitRange;
    endproperty
    a_limit: assert property (p_limit)
        else $error("Limit range not flagged");

    property p_green;
        (isOn && !limS && !faultNow) |=> statusLampGreen;
    endproperty
    a_green: assert property (p_green)
        else $error("Green lamp not steady in normal operation");

    property p_on_needs_actuator;
        $rose(safety_output_a) |-> $past(presS, 2);
    endproperty
    a_on_needs_actuator: assert property (p_on_needs_actuator)
        else $error("Output switched on without actuator");
endmodule

// >>> rtl/ssoc_pkg.sv
package ssoc_pkg;

    // Clock and timebase
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_MS = 1000000;
    localparam int CYC_PER_MS = NS_PER_MS / CLK_PERIOD_NS;

    // System times, in milliseconds
    localparam int SELFTEST_MS = 8000;
    localparam int SELFTEST_SHORT_MS = 500;
    localparam int TON_MAX_MS = 400;
    localparam int TOFF_MAX_MS = 260;
    localparam int SKEW_MAX_MS = 10;
    localparam int FLT_DET_MAX_MS = 300;
    localparam int CLR_HOLD_MS = 3000;

    // Internal choices, in milliseconds
    localparam int ON_QUAL_MS = 50;
    localparam int TP_PERIOD_MS = 250;
    localparam int TP_WIDTH_MS = 1;
    localparam int TP_B_START_MS = 5;
    localparam int MISM_FILT_MS = 3;
    localparam int FLASH_HALF_MS = 250;

    // Widths of the millisecond counters
    localparam int MS_W = 14;
    localparam int TP_W = 8;

    // Reset values
    localparam logic SAFE_OUT_RST = 1'b0;

    typedef enum logic [1:0] {
        ST_SELFTEST,
        ST_OFF,
        ST_ON,
        ST_FAULT
    } ssoc_state_t;

endpackage

// >>> rtl/ssoc_time_if.sv
interface ssoc_time_if;
    logic msTick;
    logic flash;

    modport gen (
        output msTick,
        output flash
    );

    modport sink (
        input msTick,
        input flash
    );
endinterface

// >>> rtl/ssoc_tick.sv
module ssoc_tick #(
    parameter int CYC_PER_MS = ssoc_pkg::CYC_PER_MS,
    parameter int FLASH_HALF_MS = ssoc_pkg::FLASH_HALF_MS
) (
    input wire logic clk,
    input wire logic sys_rst,
    ssoc_time_if.gen tb
);
    localparam int CW = $clog2(CYC_PER_MS);
    localparam int FW = $clog2(FLASH_HALF_MS);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);
    localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_HALF_MS - 1);

    logic [CW-1:0] cycCnt_r;
    logic [FW-1:0] flashCnt_r;
    logic tick_r;
    logic flash_r;
    wire cycWrap = (cycCnt_r == CYC_LAST);
    wire flashWrap = (flashCnt_r == FLASH_LAST);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cycCnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cycCnt_r <= cycWrap ? '0 : cycCnt_r + 1'b1;
            tick_r <= cycWrap;
        end
    end

    // Lamp flashing rate, derived from the millisecond tick
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flashCnt_r <= '0;
            flash_r <= 1'b0;
        end else if (tick_r) begin
            flashCnt_r <= flashWrap ? '0 : flashCnt_r + 1'b1;
            if (flashWrap) begin
                flash_r <= ~flash_r;
            end
        end
    end

    assign tb.msTick = tick_r;
    assign tb.flash = flash_r;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_tick_single;
        tick_r |=> !tick_r;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("Millisecond tick lasted more than one cycle");
endmodule

// >>> verification/ssoc_relay_model.sv
module ssoc_relay_model (
    input wire logic clk,
    input wire logic safety_output_a,
    input wire logic safety_output_b,
    input wire logic shortA,
    output logic readbackA,
    output logic readbackB,
    output int pulsesA,
    output int pulsesB
);
    timeunit 1ns;
    timeprecision 1ns;

    logic prevA = 1'b0;
    logic prevB = 1'b0;
    int cntA = 0;
    int cntB = 0;

    // Lines are read back as driven; the relay adds no pulsing
    // A commanded short pulls line A to the supply level
    assign readbackA = shortA ? 1'b1 : safety_output_a;
    assign readbackB = safety_output_b;
    assign pulsesA = cntA;
    assign pulsesB = cntB;

    // A dip on one channel while the other stays on is a test pulse
    always @(posedge clk) begin
        prevA <= safety_output_a;
        prevB <= safety_output_b;
        if (prevA && !safety_output_a && safety_output_b) begin
            cntA <= cntA + 1;
        end
        if (prevB && !safety_output_b && safety_output_a) begin
            cntB <= cntB + 1;
        end
    end
endmodule

// >>> verification/safety_switch_output_controller_tb.sv
module safety_switch_output_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int CYC = 10;
    logic clk, sys_rst, actInRange, actInLimit, faultClear;
    logic internalFault, shortA, readbackA, readbackB;
    logic safety_output_a, safety_output_b, door_closed_output_alt;
    logic fault_indicator_output, statusLampGreen, diagLampRed, limitRange;
    logic sawOn, sawHi, sawLo;
    logic longAct, longA, longB;
    int pulsesA, pulsesB, n_errors, checks_done, took;

    ssoc_core #(.CYC_PER_MS(CYC), .SINGLE_FACE(1'b1)) dut_u (
        .clk(clk),
        .sys_rst(sys_rst),
        .actInRange(actInRange),
        .actInLimit(actInLimit),
        .faultClear(faultClear),
        .readbackA(readbackA),
        .readbackB(readbackB),
        .internalFault(internalFault),
        .safety_output_a(safety_output_a),
        .safety_output_b(safety_output_b),
        .door_closed_output_alt(door_closed_output_alt),
        .fault_indicator_output(fault_indicator_output),
        .statusLampGreen(statusLampGreen),
        .diagLampRed(diagLampRed),
        .limitRange(limitRange)
    );

    ssoc_relay_model relay_u (
        .clk(clk),
        .safety_output_a(safety_output_a),
        .safety_output_b(safety_output_b),
        .shortA(shortA),
        .readbackA(readbackA),
        .readbackB(readbackB),
        .pulsesA(pulsesA),
        .pulsesB(pulsesB)
    );

    // Long self-test variant on a fast timebase, lines read back directly
    ssoc_core #(.CYC_PER_MS(2), .SINGLE_FACE(1'b0)) dut_long_u (
        .clk(clk),
        .sys_rst(sys_rst),
        .actInRange(longAct),
        .actInLimit(1'b0),
        .faultClear(1'b0),
        .readbackA(longA),
        .readbackB(longB),
        .internalFault(1'b0),
        .safety_output_a(longA),
        .safety_output_b(longB),
        .door_closed_output_alt(),
        .fault_indicator_output(),
        .statusLampGreen(),
        .diagLampRed(),
        .limitRange()
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Bound in clocks: the limit plus one tick of phase and sync lag
    function int msToCyc(input int ms);
        return ms * CYC + CYC + 4;
    endfunction

    function logic sig(input int sel);
        case (sel)
            0: return safety_output_a;
            1: return safety_output_b;
            2: return door_closed_output_alt;
            default: return fault_indicator_output;
        endcase
    endfunction

    task finish_test();
        $display("Errors %0d, checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task waitFor(input int sel, input logic val, input int maxCyc);
        took = 0;
        while (sig(sel) !== val && took < maxCyc) begin
            step(1);
            took++;
        end
        chk(16'(sig(sel)), 16'(val));
        if (sig(sel) !== val) begin
            finish_test();
        end
    endtask

    // Watches outputs and the green lamp for a number of milliseconds
    task watch(input int ms);
        sawOn = 1'b0;
        sawHi = 1'b0;
        sawLo = 1'b0;
        repeat (ms * CYC) begin
            step(1);
            sawOn = sawOn | safety_output_a | safety_output_b;
            sawHi = sawHi | statusLampGreen;
            sawLo = sawLo | !statusLampGreen;
        end
    endtask

    initial begin
        n_errors = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        actInRange = 1'b1;
        actInLimit = 1'b0;
        faultClear = 1'b0;
        internalFault = 1'b0;
        shortA = 1'b0;
        void'($urandom(32'h95110239));
        step(10);
        sys_rst = 1'b0;
        watch(480);
        chk(16'(sawOn), 16'h0000);
        chk(16'(sawHi & sawLo), 16'h0001);
        waitFor(0, 1'b1, msToCyc(420));
        waitFor(1, 1'b1, msToCyc(10));
        chk(16'(door_closed_output_alt), 16'h0001);
        watch(300);
        chk(16'(sawLo), 16'h0000);
        chk(16'(pulsesA > 0 && pulsesB > 0), 16'h0001);
        chk(16'(fault_indicator_output), 16'h0000);
        actInLimit = 1'b1;
        step(5);
        chk(16'(limitRange), 16'h0001);
        watch(600);
        chk(16'(sawHi & sawLo), 16'h0001);
        actInLimit = 1'b0;
        step(5);
        chk(16'(limitRange), 16'h0000);
        step($urandom_range(1, 3 * CYC));
        actInRange = 1'b0;
        waitFor(0, 1'b0, msToCyc(260));
        waitFor(1, 1'b0, msToCyc(10));
        step(5);
        chk(16'(door_closed_output_alt), 16'h0000);
        watch(600);
        chk(16'(sawHi & sawLo), 16'h0001);
        // Output fault: line A held high while the device drives it low
        shortA = 1'b1;
        waitFor(3, 1'b1, msToCyc(300));
        step(1);
        chk(16'(diagLampRed), 16'h0001);
        chk(16'(statusLampGreen), 16'h0000);
        shortA = 1'b0;
        actInRange = 1'b1;
        watch(200);
        chk(16'(sawOn), 16'h0000);
        chk(16'(fault_indicator_output), 16'h0001);
        // Too short a hold leaves the fault standing
        faultClear = 1'b1;
        step($urandom_range(500, 2500) * CYC);
        faultClear = 1'b0;
        step(5);
        chk(16'(fault_indicator_output), 16'h0001);
        faultClear = 1'b1;
        step(2990 * CYC);
        chk(16'(fault_indicator_output), 16'h0001);
        waitFor(3, 1'b0, msToCyc(20));
        faultClear = 1'b0;
        step(2);
        chk(16'(safety_output_a), 16'h0000);
        chk(16'(diagLampRed), 16'h0000);
        waitFor(0, 1'b1, msToCyc(400));
        step($urandom_range(1, 300 * CYC));
        internalFault = 1'b1;
        waitFor(3, 1'b1, msToCyc(300));
        step(1);
        chk(16'(diagLampRed), 16'h0001);
        watch(100);
        chk(16'(sawOn), 16'h0000);
        internalFault = 1'b0;
        finish_test();
    end

    // Long variant: still off 10 ms before its self-test ends, on soon after
    initial begin
        longAct = 1'b1;
        repeat (10 + 7990 * 2) @(posedge clk);
        #1;
        chk(16'(longA | longB), 16'h0000);
        repeat (200) begin
            if (!longA) begin
                @(posedge clk);
                #1;
            end
        end
        chk(16'(longA), 16'h0001);
    end
endmodule
